// ### src/epf_framer_regs.vh
// constants for the event report packet framer
`ifndef EPF_FRAMER_REGS_VH
`define EPF_FRAMER_REGS_VH

// primary header
`define EPF_VERSION        3'b000
`define EPF_TYPE           1'b0
`define EPF_DFH_FLAG       1'b1
`define EPF_APID           7'b1000111
`define EPF_CATEGORY       4'b0111
`define EPF_SEG_FLAGS      2'b11
`define EPF_GROUND_SRC     3'b000
`define EPF_LEN_OFFSET     16'h0009

// secondary header and mirror event identifier
`define EPF_STD_VERSION    3'b010
`define EPF_CKSUM_FLAG     1'b0
`define EPF_HDR_SPARE      4'b0000
`define EPF_CONN_TYPE      8'h11
`define EPF_CONN_SUBTYPE   8'h02
`define EPF_MIR_TYPE       8'h05
`define EPF_MIR_SUBTYPE    8'h02
`define EPF_MIR_PAD        8'h00
`define EPF_MIR_EID        16'ha7f9

// source data and header sizes in bytes
`define EPF_CONN_SRC_BYTES 16'h000a
`define EPF_MIR_SRC_BYTES  16'h0004
`define EPF_HDR_BYTES      16'h0010

// packet image
`define EPF_PKT_BITS       208
`define EPF_BYTE_BITS      8
`define EPF_CNT_W          6
`define EPF_CONN_BYTES     6'h1a
`define EPF_MIR_BYTES      6'h14
`define EPF_CONN_SRC_ZERO  80'h0
`define EPF_MIR_TAIL_ZERO  48'h0

// failed mirror position codes
`define EPF_POS_SPACE      2'h1
`define EPF_POS_HOT        2'h2
`define EPF_POS_COLD       2'h3

// startup wait
`define EPF_SYNC_WAIT_S    64'd60
`define EPF_CLK_HZ         64'd40000000

// register byte offsets
`define EPF_REG_CTRL       5'h00
`define EPF_REG_STATUS     5'h04
`define EPF_REG_IRQ_STAT   5'h08
`define EPF_REG_IRQ_MASK   5'h0c

// control bits
`define EPF_CTRL_STOP      0
`define EPF_CTRL_SPACE     1
`define EPF_CTRL_SYNC      2
`define EPF_CTRL_HK        3
`define EPF_CTRL_W         4

// irq bits
`define EPF_IRQ_CONN_SENT  0
`define EPF_IRQ_MIR_SENT   1
`define EPF_IRQ_CONN_REF   2
`define EPF_IRQ_OVERRUN    3
`define EPF_IRQ_W          4

// axi responses
`define EPF_RESP_OKAY      2'b00
`define EPF_RESP_SLVERR    2'b10

`endif

// ### src/epf_framer.v
// event report packet framer with axi4-lite control
//
// Summary of operation
// [RL1] packets open with version 000, type 0, data-field-header flag 1
// [RL2] application process identifier is fixed at 71
// [RL3] packet category is 7, private event report
// [RL4] segmentation flags are 11, standalone packet
// [RL5] connection count: three zero bits, then an 11-bit one-up counter from zero
// [RL6] one counter per identifier/category pair, advanced only by its own packet
// [RL7] length field is source data bytes plus nine; connection report gives 19
// [RL8] 48-bit acquisition start time: 4 bytes seconds then 2 bytes fraction
// [RL9] secondary header opens with version 010, checksum flag 0, spare 0000
// [RL10] connection report carries service type 17, subtype 2
// [RL11] connection report pad byte is copied from the triggering telecommand
// [RL12] connection report source data is all zero
// [RL13] mirror error 1 follows miss, drive back, then space position reached
// [RL14] mirror error 1 uses service type 5 and subtype 2
// [RL15] mirror error 1: pad zero, 32 bits source data, length 13
// [RL16] connection report only after startup steps and sync or sixty seconds
// [RL17] failed position coded 1 space, 2 hot, 3 cold in sixteen bits
// [RL18] fields are sent contiguously in listed order, most significant bit first
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "epf_framer_regs.vh"

module epf_framer #(
   parameter [63:0] SYNC_WAIT_CYCLES = `EPF_SYNC_WAIT_S * `EPF_CLK_HZ,
   parameter        ADDR_W           = 5
) (
   input  wire              clk,
   input  wire              rst_n,
   // axi4-lite slave
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   // onboard time
   input  wire [31:0]       coarseTimePart,
   input  wire [15:0]       fineTimePart,
   // telecommand and mirror events
   input  wire              connTestReq,
   input  wire [7:0]        connTestPad,
   input  wire              mirrorMissed,
   input  wire [1:0]        mirrorFailedPos,
   input  wire              mirrorDrivenBack,
   input  wire              mirrorAtSpace,
   input  wire              mirrorSpaceFailed,
   // packet byte stream
   output reg  [7:0]        pktByte,
   output reg               pktValid,
   output reg               pktFirst,
   output reg               pktLast,
   input  wire              pktReady,
   output reg               irq
);

   localparam MIR_IDLE   = 2'd0;
   localparam MIR_MISSED = 2'd1;
   localparam MIR_BACK   = 2'd2;

   localparam PKT_W = `EPF_PKT_BITS;
   localparam BW    = `EPF_BYTE_BITS;
   localparam CW    = `EPF_CNT_W;

   reg  [1:0]           rstPipe;
   wire                 rstSync_n = rstPipe[1];

   reg  [ADDR_W-1:0]    wrAddr;
   reg  [31:0]          wrData;
   reg  [3:0]           wrStrb;
   reg  [`EPF_CTRL_W-1:0] ctrl;
   reg  [`EPF_IRQ_W-1:0]  irqStat;
   reg  [`EPF_IRQ_W-1:0]  irqMask;

   reg  [31:0]          syncTimer;
   reg                  syncTimeout;
   wire                 startupDone;

   reg  [1:0]           mirState;
   reg  [1:0]           mirPos;
   reg                  mirPend;
   reg  [47:0]          mirTime;
   reg  [1:0]           mirPosLat;
   reg                  connPend;
   reg  [7:0]           connPad;
   reg  [47:0]          connTime;

   reg  [13:0]          seqCount;
   reg  [PKT_W-1:0]     pktShift;
   reg  [CW-1:0]        bytesLeft;
   wire [PKT_W-1:0]     connImage;
   wire [PKT_W-1:0]     mirImage;
   wire [15:0]          connLen;
   wire [15:0]          mirLen;
   wire                 loadConn;
   wire                 loadMir;
   wire                 byteTaken;
   wire                 wrFire;
   wire                 rdFire;
   wire                 rdIrqStat;
   wire                 connAccept;
   wire                 connRefuse;
   wire                 mirTrigger;
   reg  [`EPF_IRQ_W-1:0] irqSet;
   reg  [31:0]          next_rdata;
   reg  [1:0]           next_rresp;

   // reset release through two flops
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rstPipe <= 2'b00;
      else
         rstPipe <= {rstPipe[0], 1'b1};
   end

   // ---------------- axi4-lite write ----------------
   assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `EPF_RESP_OKAY;
         wrAddr        <= {ADDR_W{1'b0}};
         wrData        <= 32'h0;
         wrStrb        <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wrAddr        <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wrData       <= s_axi_wdata;
            wrStrb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            if (wrAddr == `EPF_REG_CTRL || wrAddr == `EPF_REG_IRQ_MASK ||
                wrAddr == `EPF_REG_STATUS || wrAddr == `EPF_REG_IRQ_STAT)
               s_axi_bresp <= `EPF_RESP_OKAY;
            else
               s_axi_bresp <= `EPF_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         ctrl    <= {`EPF_CTRL_W{1'b0}};
         irqMask <= {`EPF_IRQ_W{1'b0}};
      end else if (wrFire && wrStrb[0]) begin
         if (wrAddr == `EPF_REG_CTRL)
            ctrl <= wrData[`EPF_CTRL_W-1:0];
         if (wrAddr == `EPF_REG_IRQ_MASK)
            irqMask <= wrData[`EPF_IRQ_W-1:0];
      end
   end

   // ---------------- axi4-lite read ----------------
   assign rdFire    = s_axi_arvalid && s_axi_arready;
   assign rdIrqStat = rdFire && (s_axi_araddr == `EPF_REG_IRQ_STAT);

   always @* begin
      next_rdata = 32'h0;
      next_rresp = `EPF_RESP_OKAY;
      case (s_axi_araddr)
         `EPF_REG_CTRL:     next_rdata[`EPF_CTRL_W-1:0] = ctrl;
         `EPF_REG_STATUS:   next_rdata = {2'b00, seqCount, 9'h000, syncTimeout, mirPend,
                                          connPend, mirState, pktValid, startupDone};
         `EPF_REG_IRQ_STAT: next_rdata[`EPF_IRQ_W-1:0] = irqStat;
         `EPF_REG_IRQ_MASK: next_rdata[`EPF_IRQ_W-1:0] = irqMask;
         default:           next_rresp = `EPF_RESP_SLVERR;
      endcase
   end

   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `EPF_RESP_OKAY;
      end else if (rdFire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ---------------- interrupts ----------------
   always @* begin
      irqSet = {`EPF_IRQ_W{1'b0}};
      irqSet[`EPF_IRQ_CONN_SENT] = loadConn;
      irqSet[`EPF_IRQ_MIR_SENT]  = loadMir;
      irqSet[`EPF_IRQ_CONN_REF]  = connRefuse;
      irqSet[`EPF_IRQ_OVERRUN]   = (connAccept && connPend && !loadConn) ||
                                   (mirTrigger && mirPend && !loadMir);
   end

   // a new event in the clearing read survives
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         irqStat <= {`EPF_IRQ_W{1'b0}};
         irq     <= 1'b0;
      end else begin
         irqStat <= (rdIrqStat ? {`EPF_IRQ_W{1'b0}} : irqStat) | irqSet;
         irq     <= |(((rdIrqStat ? {`EPF_IRQ_W{1'b0}} : irqStat) | irqSet) & irqMask);
      end
   end

   // ---------------- startup gating ----------------
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         syncTimer   <= 32'h0;
         syncTimeout <= 1'b0;
      end else if (!syncTimeout) begin
         syncTimer <= syncTimer + 32'h1;
         if ({32'h0, syncTimer} >= SYNC_WAIT_CYCLES - 64'd1)
            syncTimeout <= 1'b1;
      end
   end

   assign startupDone = ctrl[`EPF_CTRL_STOP] && ctrl[`EPF_CTRL_SPACE] &&
                        (ctrl[`EPF_CTRL_SYNC] || syncTimeout) && ctrl[`EPF_CTRL_HK]; // RL16
   assign connAccept  = connTestReq && startupDone; // RL16
   assign connRefuse  = connTestReq && !startupDone;

   // ---------------- mirror error sequence ----------------
   assign mirTrigger = (mirState == MIR_BACK) && mirrorAtSpace; // RL13

   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         mirState <= MIR_IDLE;
         mirPos   <= `EPF_POS_SPACE;
      end else begin
         case (mirState)
            MIR_IDLE: begin
               if (mirrorMissed) begin
                  mirState <= MIR_MISSED;
                  mirPos   <= mirrorFailedPos;
               end
            end
            MIR_MISSED: begin
               if (mirrorDrivenBack)
                  mirState <= MIR_BACK;
            end
            MIR_BACK: begin
               if (mirrorAtSpace || mirrorSpaceFailed)
                  mirState <= MIR_IDLE; // RL13
            end
            default: mirState <= MIR_IDLE;
         endcase
      end
   end

   // ---------------- pending reports ----------------
   assign loadConn  = (!pktValid || (byteTaken && pktLast)) && connPend;
   assign loadMir   = (!pktValid || (byteTaken && pktLast)) && mirPend && !connPend;
   assign byteTaken = pktValid && pktReady;

   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         connPend  <= 1'b0;
         connPad   <= 8'h00;
         connTime  <= 48'h0;
         mirPend   <= 1'b0;
         mirTime   <= 48'h0;
         mirPosLat <= `EPF_POS_SPACE;
      end else begin
         if (connAccept && (!connPend || loadConn)) begin
            connPend <= 1'b1;
            connPad  <= connTestPad; // RL11
            connTime <= {coarseTimePart, fineTimePart}; // RL8
         end else if (loadConn)
            connPend <= 1'b0;
         if (mirTrigger && (!mirPend || loadMir)) begin
            mirPend   <= 1'b1;
            mirPosLat <= mirPos; // RL17
            mirTime   <= {coarseTimePart, fineTimePart}; // RL8
         end else if (loadMir)
            mirPend <= 1'b0;
      end
   end

   // ---------------- packet images ----------------
   assign connLen = `EPF_CONN_SRC_BYTES + `EPF_LEN_OFFSET; // RL7
   assign mirLen  = `EPF_MIR_SRC_BYTES + `EPF_LEN_OFFSET; // RL15

   // listed field order, msb first, no gaps
   assign connImage = {`EPF_VERSION, `EPF_TYPE, `EPF_DFH_FLAG, // RL1
                       `EPF_APID, // RL2
                       `EPF_CATEGORY, // RL3
                       `EPF_SEG_FLAGS, // RL4
                       `EPF_GROUND_SRC, seqCount[10:0], // RL5
                       connLen, connTime, // RL18
                       `EPF_STD_VERSION, `EPF_CKSUM_FLAG, `EPF_HDR_SPARE, // RL9
                       `EPF_CONN_TYPE, `EPF_CONN_SUBTYPE, // RL10
                       connPad,
                       `EPF_CONN_SRC_ZERO}; // RL12

   assign mirImage  = {`EPF_VERSION, `EPF_TYPE, `EPF_DFH_FLAG, // RL1
                       `EPF_APID, `EPF_CATEGORY, `EPF_SEG_FLAGS, // RL2
                       seqCount, mirLen, mirTime, // RL18
                       `EPF_STD_VERSION, `EPF_CKSUM_FLAG, `EPF_HDR_SPARE, // RL9
                       `EPF_MIR_TYPE, `EPF_MIR_SUBTYPE, // RL14
                       `EPF_MIR_PAD, // RL15
                       `EPF_MIR_EID, 14'h0000, mirPosLat, // RL17
                       `EPF_MIR_TAIL_ZERO};

   // both reports share the one identifier/category pair
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n)
         seqCount <= 14'h0000;
      else if (loadConn)
         seqCount <= {3'b000, seqCount[10:0] + 11'h001}; // RL5
      else if (loadMir)
         seqCount <= seqCount + 14'h0001; // RL6
   end

   // ---------------- byte serialiser ----------------
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pktShift  <= {PKT_W{1'b0}};
         bytesLeft <= {CW{1'b0}};
         pktByte   <= 8'h00;
         pktValid  <= 1'b0;
         pktFirst  <= 1'b0;
         pktLast   <= 1'b0;
      end else if (loadConn || loadMir) begin
         pktShift  <= {(loadConn ? connImage[PKT_W-BW-1:0] : mirImage[PKT_W-BW-1:0]),
                       {BW{1'b0}}};
         pktByte   <= loadConn ? connImage[PKT_W-1:PKT_W-BW] : mirImage[PKT_W-1:PKT_W-BW];
         bytesLeft <= loadConn ? `EPF_CONN_BYTES : `EPF_MIR_BYTES;
         pktValid  <= 1'b1;
         pktFirst  <= 1'b1;
         pktLast   <= 1'b0;
      end else if (byteTaken) begin
         pktShift  <= {pktShift[PKT_W-BW-1:0], {BW{1'b0}}}; // RL18
         pktByte   <= pktShift[PKT_W-1:PKT_W-BW];
         bytesLeft <= bytesLeft - {{(CW-1){1'b0}}, 1'b1};
         pktFirst  <= 1'b0;
         pktValid  <= !pktLast;
         pktLast   <= (bytesLeft == {{(CW-2){1'b0}}, 2'b10});
      end
   end

endmodule

// ### tb/epf_sink_model.sv
// telemetry sink model that collects packet bytes and can stall every other cycle
`timescale 1ns/1ps
module epf_sink_model (
   input  wire       clk,
   input  wire [7:0] pktByte,
   input  wire       pktValid,
   input  wire       slow,
   output logic      pktReady
);
   logic [7:0] pkt [$];

   initial pktReady = 1'b0;

   always @(posedge clk) begin
      pktReady <= slow ? !pktReady : 1'b1;
      if (pktValid && pktReady) begin
         pkt.push_back(pktByte);
      end
   end
endmodule

// ### tb/epf_framer_asserts.sv
// stream assertions for the event report packet framer
`timescale 1ns/1ps
module epf_framer_asserts (
   input wire       clk,
   input wire       rst_n,
   input wire [7:0] pktByte,
   input wire       pktValid,
   input wire       pktFirst,
   input wire       pktLast,
   input wire       pktReady
);
   logic [5:0] idx;
   logic [7:0] lenLo;
   wire        take   = pktValid && pktReady;
   wire        isConn = lenLo == 8'h13;

   // byte index within the packet and the low length byte of the current packet
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx <= 6'h00;
         lenLo <= 8'h00;
      end else if (take) begin
         idx <= pktLast ? 6'h00 : idx + 6'h01;
         if (idx == 6'h05) begin
            lenLo <= pktByte;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   hdr_first_a: assert property (pktValid && pktFirst |-> pktByte == 8'h0c && idx == 6'h00)
      else $error("first packet byte wrong");
   apid_cat_a: assert property (pktValid && idx == 6'h01 |-> pktByte == 8'h77)
      else $error("identifier and category byte wrong");
   seg_flags_a: assert property (pktValid && idx == 6'h02 |-> pktByte[7:6] == 2'b11)
      else $error("segmentation flags wrong");
   len_field_a: assert property (pktValid && idx == 6'h05 |-> pktByte inside {8'h13, 8'h0d})
      else $error("packet length low byte wrong");
   sec_hdr_a: assert property (pktValid && idx == 6'h0c |-> pktByte == 8'h40)
      else $error("secondary header first byte wrong");
   svc_type_a: assert property (pktValid && idx == 6'h0d |-> pktByte == (isConn ? 8'h11 : 8'h05))
      else $error("service type wrong");
   svc_sub_a: assert property (pktValid && idx == 6'h0e |-> pktByte == 8'h02)
      else $error("service subtype wrong");
   pkt_end_a: assert property (pktValid && pktLast |-> idx == (isConn ? 6'd25 : 6'd19))
      else $error("packet ends at the wrong byte");
   conn_src_a: assert property (pktValid && isConn && idx > 6'd15 |-> pktByte == 8'h00)
      else $error("connection source data not zero");
   mir_pad_a: assert property (pktValid && !isConn && idx == 6'd15 |-> pktByte == 8'h00)
      else $error("mirror pad byte not zero");
   byte_hold_a: assert property (pktValid && !pktReady |=> pktValid && $stable(pktByte))
      else $error("byte changed while stalled");
endmodule

bind epf_framer epf_framer_asserts epf_framer_asserts_inst (
   .clk(clk), .rst_n(rst_n), .pktByte(pktByte), .pktValid(pktValid),
   .pktFirst(pktFirst), .pktLast(pktLast), .pktReady(pktReady));

// ### tb/event_report_packet_framer_bench.sv
// self-checking bench for the event report packet framer
`timescale 1ns/1ps
module event_report_packet_framer_bench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [4:0]  awaddr = 5'h00;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic [4:0]  araddr = 5'h00;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [31:0] coarse = 32'h0;
   logic [15:0] fine = 16'h0;
   logic [7:0]  pad = 8'h00;
   logic [1:0]  pos = 2'h0;
   logic [4:0]  evt = 5'h00;
   logic        slow = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid;
   wire         pktValid, pktFirst, pktLast, pktReady, irq;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [7:0]   pktByte;
   int          n_errors = 0;
   int          checked = 0;
   int          cycles = 0;

   always #12.5 clk = ~clk;

   epf_framer #(.SYNC_WAIT_CYCLES(64'd50)) epf_framer_inst (
      .clk(clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .coarseTimePart(coarse), .fineTimePart(fine),
      .connTestReq(evt[0]), .connTestPad(pad), .mirrorMissed(evt[1]), .mirrorFailedPos(pos),
      .mirrorDrivenBack(evt[2]), .mirrorAtSpace(evt[3]), .mirrorSpaceFailed(evt[4]),
      .pktByte(pktByte), .pktValid(pktValid), .pktFirst(pktFirst), .pktLast(pktLast),
      .pktReady(pktReady), .irq(irq));

   epf_sink_model epf_sink_model_inst (
      .clk(clk), .pktByte(pktByte), .pktValid(pktValid), .slow(slow), .pktReady(pktReady));

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic axiWr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", er, bresp);
      // let an edge pass so a following call never reassigns bready in this step
      @(posedge clk);
   endtask

   task automatic axiRd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", ed, rdata);
      chk("rresp", er, rresp);
      // let an edge pass so a following call never reassigns rready in this step
      @(posedge clk);
   endtask

   task automatic pulse(input int b);
      evt[b] <= 1'b1;
      @(posedge clk);
      evt <= 5'h00;
      @(posedge clk);
   endtask

   // expected image: primary header, time, secondary header, source data
   task automatic chkPkt(input logic mir, input logic [13:0] cnt, input logic [7:0] v);
      logic [207:0] e;
      int           nb;
      int           w;
      e = mir ? {16'h0c77, 2'b11, cnt, 16'd13, coarse, fine, 32'h40050200, 16'ha7f9,
                 8'h00, v, 48'h0}
              : {16'h0c77, 2'b11, cnt, 16'd19, coarse, fine, 24'h401102, v, 80'h0};
      nb = mir ? 20 : 26;
      w = 0;
      while (epf_sink_model_inst.pkt.size() < nb && w < 2000) begin
         @(posedge clk);
         w++;
      end
      for (int i = 0; i < nb; i++) chk("pktByte", e[207-8*i -: 8], epf_sink_model_inst.pkt[i]);
      chk("pktBytes", nb, epf_sink_model_inst.pkt.size());
      epf_sink_model_inst.pkt.delete();
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         $display("[FAIL] cycles expected below 20000 seen %0d", cycles);
         stop_test();
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      axiRd(5'h00, 32'h0, 2'b00);
      axiRd(5'h0c, 32'h0, 2'b00);
      axiRd(5'h10, 32'h0, 2'b10);
      axiWr(5'h1c, 32'hf, 2'b10);
      axiWr(5'h0c, 32'h5, 2'b00);
      pad <= 8'h5a;
      pulse(0);
      repeat (2) @(posedge clk);
      chk("irq", 32'h1, irq);
      axiRd(5'h08, 32'h4, 2'b00);
      repeat (2) @(posedge clk);
      chk("irq", 32'h0, irq);
      chk("pktBytes", 32'h0, epf_sink_model_inst.pkt.size());
      repeat (40) @(posedge clk);
      // startup done with the sync wait elapsed instead of a time sync
      axiWr(5'h00, 32'hb, 2'b00);
      axiRd(5'h00, 32'hb, 2'b00);
      for (int k = 0; k < 2; k++) begin
         coarse <= 32'h0011_6417 + k;
         fine <= 16'ha8c3 - 16'(k);
         pad <= 8'h5a + 8'(k);
         slow <= k[0];
         pulse(0);
         chkPkt(1'b0, 14'(k), pad);
      end
      chk("irq", 32'h1, irq);
      axiRd(5'h08, 32'h1, 2'b00);
      slow <= 1'b0;
      for (int p = 1; p < 4; p++) begin
         pos <= 2'(p);
         pulse(1);
         pulse(2);
         pulse(3);
         chkPkt(1'b1, 14'(p + 1), 8'(p));
      end
      pulse(1);
      pulse(2);
      pulse(4);
      pulse(0);
      chkPkt(1'b0, 14'h5, pad);
      // status: count 6, timeout elapsed, startup done, idle
      axiRd(5'h04, 32'h0006_0041, 2'b00);
      // second reset: the time sync bit must open the gate before the timeout
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      axiWr(5'h00, 32'hb, 2'b00);
      pulse(0);
      axiRd(5'h08, 32'h4, 2'b00);
      axiWr(5'h00, 32'hf, 2'b00);
      pulse(0);
      chkPkt(1'b0, 14'h0, pad);
      stop_test();
   end
endmodule
